// File: field_bank.sv
// Configurable register field cells behind an APB slave
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns

module field_cell
  import field_bank_pkg::*;
#(
  parameter int IDX = 0
)
(
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               soft_rd,
  input  wire logic               soft_wr,
  input  wire logic [FIELD_W-1:0] wr_data,
  input  wire logic [FIELD_W-1:0] hard_in,
  input  wire logic               hard_wr_en,
  input  wire logic               soft_gate,
  input  wire logic [FIELD_W-1:0] user_rd_val,
  input  wire logic [FIELD_W-1:0] reset_ref,
  output logic      [FIELD_W-1:0] read_val,
  output logic      [FIELD_W-1:0] hard_out,
  output logic                    mod_strobe,
  output logic                    acc_strobe,
  output logic                    once_done,
  output logic                    cfg_err
);

  localparam field_cfg_type       C  = FIELD_CFG[IDX];
  localparam software_access_type SA = SOFT_ACC[IDX];
  localparam hardware_access_type HA = HARD_ACC[IDX];

  localparam bit SOFT_READS  = (SA == READ_WRITE) || (SA == READ_ONLY) ||
                               (SA == READ_WRITE_ONCE);
  localparam bit SOFT_WRITES = (SA == READ_WRITE) || (SA == WRITE_ONLY) ||
                               (SA == READ_WRITE_ONCE) ||
                               (SA == WRITE_ONCE_ONLY);
  localparam bit WRITE_ONCE  = (SA == READ_WRITE_ONCE) ||
                               (SA == WRITE_ONCE_ONLY);
  localparam bit HARD_WRITES = (HA == HARD_READ_WRITE) ||
                               (HA == HARD_WRITE_ONLY);
  localparam bit HARD_READS  = (HA == HARD_READ_WRITE) ||
                               (HA == HARD_READ_ONLY);
  localparam bit SOFT_WONLY  = (SA == WRITE_ONLY) || (SA == WRITE_ONCE_ONLY);
  localparam bit READ_EFFECT = C.clr_on_read || C.set_on_read ||
                               C.user_on_read;

  localparam bit ERR_LOST = SOFT_WRITES && (HA == HARD_WRITE_ONLY) &&
                            !C.hard_wr_en_used;
  localparam bit ERR_MEAN = (SOFT_WONLY && ((HA == HARD_WRITE_ONLY) ||
                            (HA == HARD_NO_ACCESS))) ||
                            ((SA == NO_ACCESS_SETTING) &&
                             ((HA == HARD_WRITE_ONLY) ||
                              (HA == HARD_NO_ACCESS)));

  // storage whenever state must be held
  localparam bit IS_STORAGE = SOFT_WRITES || READ_EFFECT ||
                              ((SA == READ_ONLY) &&
                               (HA == HARD_READ_WRITE)) ||
                              (HARD_WRITES && C.hard_wr_en_used) ||
                              ((SA == READ_ONLY) &&
                               (HA == HARD_WRITE_ONLY) && C.has_reset);
  localparam bit IS_WIRE    = !IS_STORAGE && HARD_WRITES;

  // no initial value given on purpose
  field_state_type st_ff;
  field_state_type nxt_st;

  logic               gate_ok;
  logic               wr_ok;
  logic [FIELD_W-1:0] cur_val;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.mod_strobe = 1'b0;
    nxt_st.acc_strobe = 1'b0;
    gate_ok = C.gate_high ? soft_gate : (C.gate_low ? !soft_gate : 1'b1);
    wr_ok = soft_wr && SOFT_WRITES && gate_ok &&
            !(WRITE_ONCE && st_ff.once_done);
    if (IS_STORAGE)
    begin
      if (C.one_shot)
      begin
        nxt_st.value = '0;
      end
      // hardware loads each clock or when enabled
      if (HARD_WRITES && (!C.hard_wr_en_used || hard_wr_en))
      begin
        nxt_st.value = hard_in;
      end
      if (wr_ok)
      begin
        // Only write-once kinds report a spent write
        nxt_st.once_done = WRITE_ONCE;
        if (C.wr1_set)
        begin
          nxt_st.value = st_ff.value | wr_data;
        end
        else if (C.wr1_clr)
        begin
          nxt_st.value = st_ff.value & ~wr_data;
        end
        else if (C.one_shot)
        begin
          nxt_st.value = '0;
          nxt_st.value[PULSE_BIT] = wr_data[PULSE_BIT];
        end
        else
        begin
          nxt_st.value = wr_data;
        end
      end
      if (soft_rd && SOFT_READS)
      begin
        if (C.clr_on_read)
        begin
          nxt_st.value = '0;
        end
        else if (C.set_on_read)
        begin
          nxt_st.value = '1;
        end
        else if (C.user_on_read)
        begin
          nxt_st.value = user_rd_val;
        end
      end
    end
    else
    begin
      // Non-storage kinds mirror their source every clock
      nxt_st.value = IS_WIRE ? hard_in : C.reset_val;
    end
    nxt_st.mod_strobe = C.notify_mod &&
                        (wr_ok || (soft_rd && SOFT_READS && READ_EFFECT));
    nxt_st.acc_strobe = C.notify_acc && (soft_rd || soft_wr);
    if (!rstn)
    begin
      nxt_st.once_done  = 1'b0;
      nxt_st.mod_strobe = 1'b0;
      nxt_st.acc_strobe = 1'b0;
      if (C.has_reset)
      begin
        nxt_st.value = C.reset_from_field ? reset_ref : C.reset_val;
      end
      else
      begin
        nxt_st.value = st_ff.value;
      end
    end
  end

  // next value is the D input
  always_ff @(posedge ref_clk)
  begin
    st_ff <= nxt_st;
  end

  // Wire kind is read straight from the hardware input
  assign cur_val    = IS_WIRE ? hard_in : st_ff.value;
  assign read_val   = SOFT_READS ? cur_val : '0;
  assign hard_out   = HARD_READS ? st_ff.value : '0;
  assign mod_strobe = st_ff.mod_strobe;
  assign acc_strobe = st_ff.acc_strobe;
  assign once_done  = st_ff.once_done;
  assign cfg_err    = ERR_LOST || ERR_MEAN;

endmodule : field_cell

module field_bank
  import field_bank_pkg::*;
(
  input  wire logic                             ref_clk,
  input  wire logic                             rstn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [ADDR_W-1:0]                paddr,
  input  wire logic [DATA_W-1:0]                pwdata,
  input  wire logic [WORD_BYTES-1:0]            pstrb,
  output logic      [DATA_W-1:0]                prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [NUM_FIELDS-1:0][FIELD_W-1:0] hard_in,
  input  wire logic [NUM_FIELDS-1:0]            hard_wr_en,
  input  wire logic [NUM_FIELDS-1:0]            soft_gate,
  input  wire logic [NUM_FIELDS-1:0][FIELD_W-1:0] user_rd_val,
  output logic      [NUM_FIELDS-1:0][FIELD_W-1:0] hard_out,
  output logic      [NUM_FIELDS-1:0]            mod_strobe,
  output logic      [NUM_FIELDS-1:0]            acc_strobe
);

  apb_state_type st_ff;
  apb_state_type nxt_st;

  logic [NUM_FIELDS-1:0][FIELD_W-1:0] read_vals;
  logic [NUM_FIELDS-1:0]              hit;
  logic [NUM_FIELDS-1:0]              field_rd;
  logic [NUM_FIELDS-1:0]              field_wr;
  logic [NUM_FIELDS-1:0]              once_flags;
  logic [NUM_FIELDS-1:0]              err_flags;
  logic                               setup;
  logic                               done;
  logic                               status_hit;
  logic [DATA_W-1:0]                  rd_word;

  assign setup      = psel && !penable;
  // Side effects land only at the completing edge
  assign done       = psel && penable && st_ff.pready;
  assign status_hit = (paddr == STATUS_ADDR);

  generate
    for (genvar i = 0; i < NUM_FIELDS; i++)
    begin : g_field
      assign hit[i]      = (paddr == field_addr(i));
      assign field_rd[i] = done && !pwrite && hit[i];
      // Field lives in byte lane zero
      assign field_wr[i] = done && pwrite && hit[i] && pstrb[0];
      field_cell #(
        .IDX (i)
      ) u_cell (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .soft_rd     (field_rd[i]),
        .soft_wr     (field_wr[i]),
        .wr_data     (pwdata[FIELD_W-1:0]),
        .hard_in     (hard_in[i]),
        .hard_wr_en  (hard_wr_en[i]),
        .soft_gate   (soft_gate[i]),
        .user_rd_val (user_rd_val[i]),
        .reset_ref   (read_vals[FIELD_CFG[i].reset_src]),
        .read_val    (read_vals[i]),
        .hard_out    (hard_out[i]),
        .mod_strobe  (mod_strobe[i]),
        .acc_strobe  (acc_strobe[i]),
        .once_done   (once_flags[i]),
        .cfg_err     (err_flags[i])
      );
    end
  endgenerate

  always_comb
  begin
    rd_word = '0;
    for (int i = 0; i < NUM_FIELDS; i++)
    begin
      if (hit[i])
      begin
        rd_word[FIELD_W-1:0] = read_vals[i];
      end
    end
    if (status_hit)
    begin
      rd_word[STATUS_ERR_LSB +: NUM_FIELDS]  = err_flags;
      rd_word[STATUS_ONCE_LSB +: NUM_FIELDS] = once_flags;
    end
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (setup)
    begin
      // One wait-free access cycle after every setup
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !(status_hit || (|hit));
      // data captured before the clearing edge
      nxt_st.prdata  = pwrite ? '0 : rd_word;
    end
    if (!rstn)
    begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st_ff <= nxt_st;
  end

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;

endmodule : field_bank

// File: field_bank_chk.sv
// Port checker for the field bank
`timescale 1ns/1ns

module field_bank_chk
  import field_bank_pkg::*;
(
  input wire logic                             ref_clk,
  input wire logic                             rstn,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [ADDR_W-1:0]                paddr,
  input wire logic [DATA_W-1:0]                pwdata,
  input wire logic [WORD_BYTES-1:0]            pstrb,
  input wire logic [DATA_W-1:0]                prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  input wire logic [NUM_FIELDS-1:0]            soft_gate,
  input wire logic [NUM_FIELDS-1:0][FIELD_W-1:0] hard_out,
  input wire logic [NUM_FIELDS-1:0]            mod_strobe,
  input wire logic [NUM_FIELDS-1:0]            acc_strobe
);
  wire done = psel && penable && pready;
  wire wdone = done && pwrite && pstrb[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_rst_val;
    rstn && !$past(rstn) |-> hard_out[1] == 8'h5a && !pready;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("reset value not held");
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready timing wrong");
  property p_err;
    done && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h028);
  endproperty
  a_err: assert property (p_err)
    else $error("pslverr wrong for address");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error response carries data");
  property p_upper;
    pready && !pwrite && paddr < 12'h028 |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  property p_oneshot;
    wdone && paddr == 12'h018 && pwdata[0] |=>
      hard_out[6][0] ##1 !hard_out[6][0];
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("one-shot pulse wrong");
  property p_clr_read;
    done && !pwrite && paddr == 12'h008 |=> hard_out[2] == 8'h00;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("clear on read missing");
  property p_wo1c;
    wdone && paddr == 12'h004 |=>
      hard_out[1] == ($past(hard_out[1]) & ~$past(pwdata[7:0]));
  endproperty
  a_wo1c: assert property (p_wo1c)
    else $error("write one clear wrong");
  property p_wo1s;
    wdone && paddr == 12'h010 && soft_gate[4] |=>
      hard_out[4] == ($past(hard_out[4]) | $past(pwdata[7:0]));
  endproperty
  a_wo1s: assert property (p_wo1s)
    else $error("write one set wrong");
  property p_gate;
    wdone && paddr == 12'h010 && !soft_gate[4] |=> $stable(hard_out[4]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("closed gate let write in");
  property p_mod;
    done && paddr == 12'h000 && (!pwrite || pstrb[0]) |=>
      mod_strobe[0] == $past(pwrite);
  endproperty
  a_mod: assert property (p_mod)
    else $error("modify strobe wrong");
  property p_acc;
    acc_strobe[5] |-> $past(done) && $past(paddr) == 12'h014;
  endproperty
  a_acc: assert property (p_acc)
    else $error("access strobe without access");

  c_oneshot: cover property (wdone && paddr == 12'h018);
  c_err: cover property (pslverr);
  c_clr: cover property (done && !pwrite && paddr == 12'h008);
endmodule : field_bank_chk

bind field_bank field_bank_chk i_chk (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .soft_gate(soft_gate), .hard_out(hard_out),
  .mod_strobe(mod_strobe), .acc_strobe(acc_strobe)
);

// File: field_bank_far.sv
// Surrounding logic model on the field hardware ports
`timescale 1ns/1ns

module field_bank_far
  import field_bank_pkg::*;
(
  output logic [NUM_FIELDS-1:0][FIELD_W-1:0] hard_in,
  output logic [NUM_FIELDS-1:0]              hard_wr_en,
  output logic [NUM_FIELDS-1:0]              soft_gate,
  output logic [NUM_FIELDS-1:0][FIELD_W-1:0] user_rd_val
);
  initial
  begin
    for (int i = 0; i < NUM_FIELDS; i++)
    begin
      hard_in[i]     = 8'h30 + 8'(i);
      user_rd_val[i] = 8'hc0 + 8'(i);
    end
    hard_wr_en = '0;
    soft_gate  = '0;
  end

  // hardware value, write enable and gate levels
  // Called right after an edge, so updates land off the sampling edge
  task automatic set(input int i, input logic [7:0] v, input logic e,
                     input logic g);
    hard_in[i]    <= v;
    hard_wr_en[i] <= e;
    soft_gate[i]  <= g;
  endtask : set
endmodule : field_bank_far

// File: field_bank_pkg.sv
// Shared constants, configuration and state types for the field bank
package field_bank_pkg;

  localparam int NUM_FIELDS = 10;
  localparam int FIELD_W    = 8;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 12;
  localparam int WORD_BYTES = 4;

  localparam logic [ADDR_W-1:0] FIELD_BASE  = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h028;
  localparam int STATUS_ERR_LSB  = 0;
  localparam int STATUS_ONCE_LSB = 16;
  localparam int PULSE_BIT       = 0;

  typedef enum logic [2:0] {
    READ_WRITE,
    READ_ONLY,
    WRITE_ONLY,
    READ_WRITE_ONCE,
    WRITE_ONCE_ONLY,
    NO_ACCESS_SETTING
  } software_access_type;

  typedef enum logic [1:0] {
    HARD_READ_WRITE,
    HARD_READ_ONLY,
    HARD_WRITE_ONLY,
    HARD_NO_ACCESS
  } hardware_access_type;

  typedef struct packed {
    logic               has_reset;
    logic               reset_from_field;
    logic [3:0]         reset_src;
    logic [FIELD_W-1:0] reset_val;
    logic               hard_wr_en_used;
    logic               clr_on_read;
    logic               set_on_read;
    logic               user_on_read;
    logic               wr1_set;
    logic               wr1_clr;
    logic               gate_high;
    logic               gate_low;
    logic               notify_mod;
    logic               notify_acc;
    logic               one_shot;
  } field_cfg_type;

  typedef struct packed {
    logic [FIELD_W-1:0] value;
    logic               once_done;
    logic               mod_strobe;
    logic               acc_strobe;
  } field_state_type;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_state_type;

  localparam software_access_type SOFT_ACC [NUM_FIELDS] = '{
    READ_WRITE, READ_WRITE, READ_ONLY, READ_ONLY, READ_WRITE,
    READ_WRITE_ONCE, READ_WRITE, READ_WRITE, READ_ONLY, READ_ONLY};

  localparam hardware_access_type HARD_ACC [NUM_FIELDS] = '{
    HARD_READ_WRITE, HARD_READ_ONLY, HARD_READ_WRITE, HARD_WRITE_ONLY,
    HARD_READ_ONLY, HARD_READ_ONLY, HARD_READ_ONLY, HARD_READ_WRITE,
    HARD_WRITE_ONLY, HARD_READ_ONLY};

  localparam field_cfg_type FIELD_CFG [NUM_FIELDS] = '{
    '{has_reset: 1'b1, hard_wr_en_used: 1'b1, notify_mod: 1'b1,
      notify_acc: 1'b1, default: '0},
    '{has_reset: 1'b1, reset_val: 8'h5a, wr1_clr: 1'b1,
      notify_mod: 1'b1, default: '0},
    '{has_reset: 1'b1, hard_wr_en_used: 1'b1, clr_on_read: 1'b1,
      notify_mod: 1'b1, default: '0},
    '{default: '0},
    '{has_reset: 1'b1, reset_from_field: 1'b1, reset_src: 4'h1,
      wr1_set: 1'b1, gate_high: 1'b1, default: '0},
    '{has_reset: 1'b1, gate_low: 1'b1, notify_acc: 1'b1, default: '0},
    '{has_reset: 1'b1, one_shot: 1'b1, default: '0},
    '{hard_wr_en_used: 1'b1, user_on_read: 1'b1, notify_mod: 1'b1,
      notify_acc: 1'b1, default: '0},
    '{has_reset: 1'b1, reset_val: 8'h11, default: '0},
    '{has_reset: 1'b1, reset_val: 8'ha5, set_on_read: 1'b0,
      default: '0}};

  function automatic logic [ADDR_W-1:0] field_addr(input int idx);
    field_addr = FIELD_BASE + ADDR_W'(idx * WORD_BYTES);
  endfunction : field_addr

endpackage : field_bank_pkg

// File: field_bank_tb_top.sv
// Self-checking bench for the field bank
`timescale 1ns/1ns

module field_bank_tb_top
  import field_bank_pkg::*;
;
  logic                               ref_clk = 1'b0;
  logic                               rstn = 1'b0;
  logic                               psel = 1'b0;
  logic                               penable = 1'b0;
  logic                               pwrite = 1'b0;
  logic [ADDR_W-1:0]                  paddr = '0;
  logic [DATA_W-1:0]                  pwdata = '0;
  logic [WORD_BYTES-1:0]              pstrb = 4'hf;
  logic [DATA_W-1:0]                  prdata;
  logic                               pready;
  logic                               pslverr;
  logic [NUM_FIELDS-1:0][FIELD_W-1:0] hard_in;
  logic [NUM_FIELDS-1:0][FIELD_W-1:0] user_rd_val;
  logic [NUM_FIELDS-1:0][FIELD_W-1:0] hard_out;
  logic [NUM_FIELDS-1:0]              hard_wr_en;
  logic [NUM_FIELDS-1:0]              soft_gate;
  logic [NUM_FIELDS-1:0]              mod_strobe;
  logic [NUM_FIELDS-1:0]              acc_strobe;
  int                                 n_errors = 0;
  int                                 tests_run = 0;

  always #25 ref_clk = ~ref_clk;

  field_bank i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hard_in(hard_in), .hard_wr_en(hard_wr_en), .soft_gate(soft_gate),
    .user_rd_val(user_rd_val), .hard_out(hard_out),
    .mod_strobe(mod_strobe), .acc_strobe(acc_strobe)
  );

  field_bank_far i_far (
    .hard_in(hard_in), .hard_wr_en(hard_wr_en), .soft_gate(soft_gate),
    .user_rd_val(user_rd_val)
  );

  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Waits on pready itself; the slave latency is never assumed
  task automatic apb(input logic w, input int i, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= 12'(4 * i);
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      check("pready", 32'h1, 32'h0);
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int i, input logic [7:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'b1, i, {24'h0, d}, r, er);
  endtask : wr

  task automatic rd(input int i, input logic [31:0] e);
    logic [31:0] r;
    logic        er;
    apb(1'b0, i, 32'h0, r, er);
    check("prdata", e, r);
    check("pslverr", {31'h0, i > 10}, {31'h0, er});
  endtask : rd

  task automatic do_reset(input int n);
    rstn <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask : do_reset

  initial
  begin
    do_reset(8);
    rd(1, 32'h5a);
    rd(4, 32'h5a);
    rd(9, 32'ha5);
    rd(3, 32'h33);
    rd(8, 32'h38);
    rd(10, 32'h0);
    rd(11, 32'h0);
    wr(1, 8'h0f);
    rd(1, 32'h50);
    i_far.set(4, 8'h34, 1'b0, 1'b1);
    wr(4, 8'h05);
    rd(4, 32'h5f);
    i_far.set(4, 8'h34, 1'b0, 1'b0);
    wr(4, 8'ha0);
    rd(4, 32'h5f);
    wr(9, 8'h00);
    rd(9, 32'ha5);
    i_far.set(5, 8'h35, 1'b0, 1'b1);
    wr(5, 8'h33);
    rd(5, 32'h0);
    i_far.set(5, 8'h35, 1'b0, 1'b0);
    wr(5, 8'h33);
    wr(5, 8'h44);
    rd(5, 32'h33);
    rd(10, 32'h0020_0000);
    i_far.set(2, 8'h77, 1'b1, 1'b0);
    @(posedge ref_clk);
    i_far.set(2, 8'h77, 1'b0, 1'b0);
    rd(2, 32'h77);
    rd(2, 32'h0);
    i_far.set(0, 8'h99, 1'b0, 1'b0);
    wr(0, 8'h21);
    rd(0, 32'h21);
    i_far.set(0, 8'h99, 1'b1, 1'b0);
    @(posedge ref_clk);
    i_far.set(0, 8'h99, 1'b0, 1'b0);
    rd(0, 32'h99);
    pstrb <= 4'he;
    wr(0, 8'h12);
    pstrb <= 4'hf;
    rd(0, 32'h99);
    wr(6, 8'h01);
    rd(6, 32'h0);
    wr(7, 8'h12);
    // Mid-run reset: field 4 must copy field 1 as it stands now
    // One edge only; a second would copy field 1's reset value
    do_reset(1);
    rd(7, 32'h12);
    rd(7, 32'hc7);
    rd(4, 32'h50);
    rd(1, 32'h5a);
    rd(10, 32'h0);
    wr(5, 8'h44);
    rd(5, 32'h44);
    conclude();
  end

  initial
  begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule : field_bank_tb_top
